/* File: rivp_top.sv */
// Reset and interrupt vector address generator with relocatable table
// Operation
// - One reset vector at 0x000 for pin, power-on, brown-out and watchdog reset.
// - External request zero vectors at 0x001, request one at 0x002.
// - Timer vectors occupy 0x003 to 0x009 in the fixed timer order.
// - Serial vectors occupy 0x00A to 0x00D in the fixed serial order.
// - Converter, eeprom, comparator, two-wire, program store vectors at 0x00E to 0x012.
// - Programmed boot-reset fuse starts execution at the boot reset address.
// - Select bit set adds boot section start to every interrupt vector.
// - Reset at 0x000 or boot address; vectors from 0x001 or boot plus 0x001.
// - Fuse value 1 means unprogrammed, 0 means programmed.
// - Vector fetched only for an enabled source that requests service.
// - Unused slots of the other section are never fetched.
// - Interrupts blocked from unlock until after next instruction, else four cycles.
`timescale 1ns/1ps
module rivp_top #(
   parameter int ADDR_W = rivp_pkg::ADDR_W,
   parameter int N_SRC = rivp_pkg::N_SRC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Straps
   input wire logic boot_reset_fuse,
   input wire logic [ADDR_W-1:0] boot_reset_addr,
   // Peripheral requests, already gated by their own enables
   input wire logic [N_SRC-1:0] irq_req,
   output logic [N_SRC-1:0] irq_ack,
   // Control writes from the core
   input wire logic ctrl_wr,
   input wire rivp_pkg::rivp_ctrl_t ctrl_wdata,
   // Core handshake
   input wire logic core_irq_enable,
   input wire logic core_instr_done,
   input wire logic core_reset_taken,
   input wire logic core_vector_taken,
   output logic reset_fetch_valid,
   output logic [ADDR_W-1:0] reset_fetch_addr,
   output logic vector_valid,
   output logic [ADDR_W-1:0] vector_addr,
   // Status
   output logic vector_table_in_boot,
   output logic vector_change_unlock,
   output logic irq_blocked
);
   rivp_pkg::rivp_state_t q;
   rivp_pkg::rivp_state_t next_q;
   logic req_any;
   logic [rivp_pkg::SRC_W-1:0] req_idx;
   logic blocked;
   logic fuse_programmed;
   logic reset_entry_now;
   logic unlock_write;
   logic select_write;
   logic instr_release;
   logic take_now;
   logic grant_now;
   logic [ADDR_W-1:0] slot_addr [N_SRC];
   logic [N_SRC-1:0] slot_granted;

   rivp_prio #(
      .N(N_SRC),
      .W(rivp_pkg::SRC_W)
   ) u_prio (
      .req(irq_req),
      .any(req_any),
      .idx(req_idx)
   );

   assign blocked = (q.unlock_left != 3'h0) || q.wait_instr;

   // Table address of every source, moved into the boot section when selected
   genvar s;
   generate
      for (s = 0; s < N_SRC; s++)
      begin : g_slot
         assign slot_addr[s] = q.sel ? ADDR_W'(boot_reset_addr + rivp_pkg::VEC_TABLE[s])
                                     : ADDR_W'(rivp_pkg::VEC_TABLE[s]);
         assign slot_granted[s] = q.vec_valid && (int'(q.vec_src) == s);
      end
   endgenerate

   assign fuse_programmed = (q.fuse_s2 == rivp_pkg::FUSE_PROGRAMMED);
   assign reset_entry_now = (q.rst_cnt == 2'h1);
   assign unlock_write = ctrl_wr && ctrl_wdata.unlock;
   // A write with unlock clear counts only inside the window
   assign select_write = ctrl_wr && !ctrl_wdata.unlock && (q.unlock_left != 3'h0);
   assign instr_release = q.wait_instr && core_instr_done;
   assign take_now = q.vec_valid && core_vector_taken;
   assign grant_now = !q.vec_valid && !q.rst_valid && !blocked && core_irq_enable && req_any;

   always_comb
   begin
      next_q = q;
      next_q.ack = '0;
      next_q.fuse_s1 = boot_reset_fuse;
      next_q.fuse_s2 = q.fuse_s1;

      // Reset entry chosen once the fuse has passed the synchroniser
      if (q.rst_cnt != 2'h0)
      begin
         next_q.rst_cnt = q.rst_cnt - 2'h1;
      end
      if (reset_entry_now)
      begin
         next_q.rst_valid = 1'b1;
         if (fuse_programmed)
         begin
            next_q.rst_addr = boot_reset_addr;
         end
         else
         begin
            next_q.rst_addr = rivp_pkg::RESET_VEC;
         end
      end
      if (q.rst_valid && core_reset_taken)
      begin
         next_q.rst_valid = 1'b0;
      end

      // Timed select change
      if (unlock_write)
      begin
         next_q.unlock_left = rivp_pkg::UNLOCK_CYCLES;
      end
      else if (select_write)
      begin
         next_q.sel = ctrl_wdata.select;
         next_q.unlock_left = 3'h0;
         next_q.wait_instr = 1'b1;
      end
      else if (q.unlock_left != 3'h0)
      begin
         next_q.unlock_left = q.unlock_left - 3'h1;
      end
      if (instr_release)
      begin
         next_q.wait_instr = 1'b0;
      end

      // Vector grant; the global enable is only read, never changed
      if (take_now)
      begin
         next_q.vec_valid = 1'b0;
         next_q.ack = slot_granted;
      end
      else if (grant_now)
      begin
         next_q.vec_valid = 1'b1;
         next_q.vec_src = req_idx;
         next_q.vec_addr = slot_addr[req_idx];
      end
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         q <= '0;
         q.rst_cnt <= rivp_pkg::RST_SETTLE;
      end
      else
      begin
         q <= next_q;
      end
   end

   assign irq_ack = q.ack;
   assign reset_fetch_valid = q.rst_valid;
   assign reset_fetch_addr = q.rst_addr;
   assign vector_valid = q.vec_valid;
   assign vector_addr = q.vec_addr;
   assign vector_table_in_boot = q.sel;
   assign vector_change_unlock = (q.unlock_left != 3'h0);
   assign irq_blocked = blocked;
endmodule : rivp_top

/* File: rivp_pkg.sv */
// Shared constants and carrier types for the reset and interrupt vector placement block
package rivp_pkg;
   localparam int ADDR_W = 12;
   localparam int N_SRC = 18;
   localparam int SRC_W = 5;
   localparam logic [ADDR_W-1:0] RESET_VEC = 12'h000;
   // Source order: ext0, ext1, t2 cmp, t2 ovf, t1 capt, t1 cmpa, t1 cmpb, t1 ovf, t0 ovf,
   // serial transfer, rx, tx empty, tx done, adc, eeprom, comparator, two-wire, program store
   localparam logic [N_SRC-1:0][ADDR_W-1:0] VEC_TABLE = {
      12'h012, 12'h011, 12'h010, 12'h00f, 12'h00e,
      12'h00d, 12'h00c, 12'h00b, 12'h00a,
      12'h009, 12'h008, 12'h007, 12'h006, 12'h005, 12'h004, 12'h003,
      12'h002, 12'h001};
   localparam logic FUSE_PROGRAMMED = 1'b0;
   localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
   localparam logic [1:0] RST_SETTLE = 2'h3;

   typedef struct packed {
      logic select;
      logic unlock;
   } rivp_ctrl_t;

   typedef struct packed {
      logic fuse_s1;
      logic fuse_s2;
      logic [1:0] rst_cnt;
      logic rst_valid;
      logic [ADDR_W-1:0] rst_addr;
      logic sel;
      logic [2:0] unlock_left;
      logic wait_instr;
      logic vec_valid;
      logic [ADDR_W-1:0] vec_addr;
      logic [SRC_W-1:0] vec_src;
      logic [N_SRC-1:0] ack;
   } rivp_state_t;
endpackage : rivp_pkg

/* File: rivp_prio.sv */
// Lowest-index-first priority encoder for the interrupt requests
`timescale 1ns/1ps
module rivp_prio #(
   parameter int N = 19,
   parameter int W = 5
) (
   // Requests
   input wire logic [N-1:0] req,
   // Result
   output logic any,
   output logic [W-1:0] idx
);
   logic [N:0] lower_any;
   logic [N-1:0] win;

   assign lower_any[0] = 1'b0;
   genvar i;
   generate
      for (i = 0; i < N; i++)
      begin : g_bit
         assign win[i] = req[i] & ~lower_any[i];
         assign lower_any[i+1] = lower_any[i] | req[i];
      end
   endgenerate

   assign any = lower_any[N];

   always_comb
   begin
      idx = '0;
      for (int k = 0; k < N; k++)
      begin
         if (win[k])
         begin
            idx = W'(k);
         end
      end
   end
endmodule : rivp_prio

/* File: rivp_monitor.sv */
// Checker for the vector generator ports
`timescale 1ns/1ps
module rivp_monitor #(parameter int ADDR_W = 12, parameter int N_SRC = 18) (
   // Watched ports
   input wire logic clk,
   input wire logic reset,
   input wire logic boot_reset_fuse,
   input wire logic [ADDR_W-1:0] boot_reset_addr,
   input wire logic [N_SRC-1:0] irq_req,
   input wire logic [N_SRC-1:0] irq_ack,
   input wire logic ctrl_wr,
   input wire rivp_pkg::rivp_ctrl_t ctrl_wdata,
   input wire logic core_irq_enable,
   input wire logic core_vector_taken,
   input wire logic reset_fetch_valid,
   input wire logic [ADDR_W-1:0] reset_fetch_addr,
   input wire logic vector_valid,
   input wire logic [ADDR_W-1:0] vector_addr,
   input wire logic vector_table_in_boot,
   input wire logic vector_change_unlock,
   input wire logic irq_blocked
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   a_reset_addr: assert property ($rose(reset_fetch_valid) |->
      reset_fetch_addr == (boot_reset_fuse ? '0 : boot_reset_addr)) else $error("reset addr");
   a_vec_first: assert property ($rose(vector_valid) && $past(irq_req[0]) |->
      vector_addr == (vector_table_in_boot ? boot_reset_addr : '0) + 1) else $error("vec addr");
   a_ack_pulse: assert property (vector_valid && core_vector_taken |=>
      !vector_valid && $onehot(irq_ack)) else $error("ack");
   a_vec_hold: assert property (vector_valid && !core_vector_taken |=>
      vector_valid && $stable(vector_addr)) else $error("vec hold");
   a_unlock_blk: assert property (ctrl_wr && ctrl_wdata.unlock |=>
      vector_change_unlock && irq_blocked) else $error("unlock");
   a_unlock_end: assert property (ctrl_wr && ctrl_wdata.unlock ##1 !ctrl_wr [*4] |=>
      !vector_change_unlock) else $error("window");
   a_no_vec: assert property (irq_blocked || !core_irq_enable |=>
      !$rose(vector_valid)) else $error("blocked");
   a_sel_keep: assert property (ctrl_wr && (ctrl_wdata.unlock || !vector_change_unlock) |=>
      $stable(vector_table_in_boot)) else $error("select");
   cover property (vector_valid && vector_table_in_boot);
   cover property (ctrl_wr && vector_change_unlock && !ctrl_wdata.unlock);
   cover property ($rose(reset_fetch_valid) && !boot_reset_fuse);
endmodule : rivp_monitor
bind rivp_top rivp_monitor #(.ADDR_W(ADDR_W), .N_SRC(N_SRC)) u_mon (.*);

/* File: rivp_core_model.sv */
// Core that takes the reset fetch and vectors, promptly or slowly
`timescale 1ns/1ps
module rivp_core_model (
   // Core side
   input wire logic clk,
   input wire logic reset,
   input wire logic slow,
   input wire logic reset_fetch_valid,
   input wire logic vector_valid,
   output logic core_reset_taken,
   output logic core_vector_taken,
   output logic core_instr_done
);
   logic [2:0] age;
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         {core_reset_taken, core_vector_taken, core_instr_done, age} <= '0;
      else
      begin
         core_reset_taken <= reset_fetch_valid && !core_reset_taken;
         age <= vector_valid ? age + 3'h1 : 3'h0;
         core_vector_taken <= vector_valid && !core_vector_taken && (!slow || age == 3'h5);
         core_instr_done <= !core_instr_done;
      end
   end
endmodule : rivp_core_model

/* File: rivp_top_tb.sv */
// Self-checking bench for the vector generator
`timescale 1ns/1ps
module rivp_top_tb;
   logic clk, reset, boot_reset_fuse, ctrl_wr, core_irq_enable, core_instr_done, slow;
   logic core_reset_taken, core_vector_taken, reset_fetch_valid, vector_valid;
   logic vector_table_in_boot, vector_change_unlock, irq_blocked;
   logic [11:0] boot_reset_addr, reset_fetch_addr, vector_addr;
   logic [17:0] irq_req, irq_ack;
   rivp_pkg::rivp_ctrl_t ctrl_wdata;
   int num_errors, checks_done, sel;
   rivp_top u_dut (.*);
   rivp_core_model u_core (.*);
   initial
   begin
      clk = 0;
      forever #12.5 clk = !clk;
   end
   task automatic check(logic [11:0] seen, logic [11:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("BAD %0t %h %h", $time, seen, exp);
      end
   endtask : check
   task automatic stop_test();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : stop_test
   function automatic logic [11:0] lowest(logic [17:0] r);
      lowest = 12'h0;
      for (int i = 17; i >= 0; i--)
         if (r[i])
            lowest = 12'(i + 1);
   endfunction : lowest
   // Reference: lowest pending source, moved by the select bit
   always @(posedge clk)
      if (vector_valid && core_vector_taken)
      begin
         check(vector_addr, lowest(irq_req) + (sel ? boot_reset_addr : 12'h0));
         irq_req[lowest(irq_req) - 1] <= 1'b0;
      end
   task automatic boot(logic f);
      reset <= 1;
      boot_reset_fuse <= f;
      repeat (10) @(posedge clk);
      reset <= 0;
      sel = 0;
      repeat (3) @(posedge clk);
      #1 check(reset_fetch_addr, f ? 12'h0 : boot_reset_addr);
   endtask : boot
   task automatic serve(logic [17:0] m);
      @(posedge clk);
      irq_req <= irq_req | m;
      for (int i = 0; i < 300 && (i == 0 || irq_req != 0); i++)
         @(posedge clk);
      check({11'h0, |irq_req}, 12'h0);
   endtask : serve
   task automatic ctl(logic [1:0] d);
      @(posedge clk);
      ctrl_wr <= 1;
      ctrl_wdata <= d;
      @(posedge clk);
      ctrl_wr <= 0;
   endtask : ctl
   initial
   begin
      {reset, irq_req, ctrl_wr, ctrl_wdata, slow} = '0;
      boot_reset_fuse = 1;
      core_irq_enable = 1;
      boot_reset_addr = 12'hc00;
      void'($urandom(32'hbd981384));
      boot(1);
      for (int i = 0; i < 18; i++)
         serve(18'h1 << i);
      slow <= 1;
      repeat (20) serve(18'($urandom));
      ctl(2'h1);
      ctl(2'h2);
      sel = 1;
      repeat (5) serve(18'($urandom));
      ctl(2'h1);
      @(posedge clk);
      check({11'h0, irq_blocked}, 12'h1);
      repeat (5) @(posedge clk);
      check({11'h0, irq_blocked}, 12'h0);
      ctl(2'h0);
      @(posedge clk);
      check({11'h0, vector_table_in_boot}, 12'h1);
      core_irq_enable <= 0;
      serve(18'h0);
      irq_req <= 18'h5;
      repeat (8) @(posedge clk);
      check({11'h0, vector_valid}, 12'h0);
      core_irq_enable <= 1;
      serve(19'h0);
      boot(0);
      serve(18'($urandom));
      stop_test();
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      num_errors++;
      stop_test();
   end
endmodule : rivp_top_tb
